// >>> include/tisa_pkg.sv
// Constants, register map and state encoding for the transceiver interrupt block
package tisa_pkg;

  localparam logic [7:0] LATCH_SET_ADDR  = 8'h0A;
  localparam logic [7:0] LATCH_CLR_ADDR  = 8'h0B;
  localparam logic [7:0] FALL_SET_ADDR   = 8'h0C;
  localparam logic [7:0] FALL_CLR_ADDR   = 8'h0D;
  localparam logic [7:0] RISE_SET_ADDR   = 8'h0E;
  localparam logic [7:0] RISE_CLR_ADDR   = 8'h0F;

  localparam logic [7:0] REG_RESET_VAL   = 8'h00;
  localparam logic [7:0] NO_RSV_MASK     = 8'h00;
  localparam logic [7:0] FALL_RSV_MASK   = 8'h40;

  localparam logic [5:0] SLAVE_ADDR_HI   = 6'h16;
  localparam logic       RW_WRITE        = 1'h0;
  localparam logic [2:0] BYTE_LAST_BIT   = 3'h7;
  localparam logic [2:0] BIT_STEP        = 3'h1;
  localparam logic [7:0] PTR_STEP        = 8'h01;
  localparam logic       SDA_DRIVE_LOW   = 1'h0;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_REG  = 3'b010,
    ST_DATA = 3'b011,
    ST_ACK  = 3'b100
  } tisa_state_t;

endpackage

// >>> logic/tisa_sync.sv
// Two flip-flop level synchroniser of parameterised width
module tisa_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] hold_ff;

  // No reset: pins carry no reset meaning, and reset must cross through here
  always_ff @(posedge clk)
  begin
    meta_ff <= d;
    hold_ff <= meta_ff;
  end

  assign q = hold_ff;

endmodule

// >>> logic/tisa_srreg.sv
// Eight-bit register with separate set and clear write strobes plus hardware set
module tisa_srreg
  import tisa_pkg::*;
#(
  parameter logic [7:0] RSV_MASK = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       set_we,
  input  wire logic       clr_we,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] hw_set,
  output logic      [7:0] q
);

  logic [7:0] val_ff;
  logic [7:0] nxt_val;

  always_comb
  begin
    nxt_val = val_ff;
    if (clr_we)
    begin
      nxt_val = nxt_val & ~wdata;
    end
    if (set_we)
    begin
      nxt_val = nxt_val | wdata;
    end
    // Set after clear, so an edge in the clearing cycle is kept
    nxt_val = (nxt_val | hw_set) & ~RSV_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      val_ff <= REG_RESET_VAL;
    end
    else
    begin
      val_ff <= nxt_val;
    end
  end

  assign q = val_ff;

endmodule

// >>> logic/tisa_top.sv
// Edge interrupt latch with serial slave write front-end on the link clock
//
// Operation
// - Rise enable bit set lets a 0-to-1 source change raise an interrupt.
// - Rise enable is 8 bits, reset zero, set 0Eh, clear 0Fh, fixed order.
// - Writing 1 at the latch set address sets that latch bit.
// - Latch bit sets on source rising edge when its rise enable is 1.
// - Latch bit sets on source falling edge when its fall enable is 1.
// - Interrupt pin is low while any latch bit is 1.
// - Interrupt pin releases only after software clears every latch bit.
// - Source levels and latch bits stay readable after an interrupt.
// - Slave answers address 010110 followed by the strapped low bit.
// - Low address bit is taken from the strap pin as reset rises.
// - Without a reset pulse the low address bit stays zero.
// - Address byte bit 0 is direction: 0 write, 1 read.
// - One-byte write puts one data byte into the addressed register.
// - Burst write fills consecutive registers from the start address.
// - Fall enable bits act on 1-to-0 changes, set 0Ch, clear 0Dh, bit 6 reserved.
// - Latch is eight bits, same order, reset zero, set 0Ah, clear 0Bh.
module tisa_top
  import tisa_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       link_clk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_strap_pin,
  input  wire logic       plus_line_irq_src,
  input  wire logic       disc_conn_src,
  input  wire logic       id_open_src,
  input  wire logic       minus_line_high_src,
  input  wire logic       id_grounded_src,
  input  wire logic       plus_line_high_src,
  input  wire logic       session_ok_src,
  input  wire logic       bus_volt_ok_src,
  output logic            int_n,
  output logic            addr_low_bit,
  output logic      [7:0] src_level,
  output logic      [7:0] latch_state,
  output logic      [7:0] rise_en_state,
  output logic      [7:0] fall_en_state
);

  // Link domain signals
  logic [1:0]  pin_s;
  logic        scl_s;
  logic        sda_s;
  logic        scl_d_ff;
  logic        sda_d_ff;
  logic        link_rstn;
  logic        low_bit_link;
  logic        start_det;
  logic        stop_det;
  logic        scl_rise;
  logic        scl_fall;
  logic        byte_end;
  logic        ack_byte;
  logic        addr_match;
  tisa_state_t state_ff;
  tisa_state_t ack_next_ff;
  tisa_state_t follow_state;
  logic [2:0]  bitcnt_ff;
  logic        byte_done_ff;
  logic [7:0]  shreg_ff;
  logic [7:0]  ptr_ff;
  logic        sda_oe_ff;
  logic        sda_out_ff;
  logic        wr_tog_ff;
  logic [7:0]  wr_addr_ff;
  logic [7:0]  wr_data_ff;

  // System domain signals
  logic        tog_s;
  logic        tog_d_ff;
  logic        wr_fire;
  logic        strap_s;
  logic        in_reset_ff;
  logic        addr_low_bit_ff = 1'h0;
  logic [7:0]  src_raw;
  logic [7:0]  src_s;
  logic [7:0]  src_prev_ff;
  logic        primed_ff;
  logic [7:0]  src_rise;
  logic [7:0]  src_fall;
  logic [7:0]  latch_hw_set;
  logic [7:0]  latch_q;
  logic [7:0]  rise_q;
  logic [7:0]  fall_q;
  logic [7:0]  src_level_ff;
  logic        int_n_ff;
  logic        latch_set_we;
  logic        latch_clr_we;
  logic        fall_set_we;
  logic        fall_clr_we;
  logic        rise_set_we;
  logic        rise_clr_we;

  // Link side: pins and reset brought onto the link clock
  tisa_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk (link_clk),
    .d   ({scl_in, sda_in}),
    .q   (pin_s)
  );

  tisa_sync #(
    .WIDTH (1)
  ) u_link_rst_sync (
    .clk (link_clk),
    .d   (resetn),
    .q   (link_rstn)
  );

  // Strapped bit is quasi-static once captured, so a level crossing suffices
  tisa_sync #(
    .WIDTH (1)
  ) u_low_bit_sync (
    .clk (link_clk),
    .d   (addr_low_bit_ff),
    .q   (low_bit_link)
  );

  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  always_ff @(posedge link_clk)
  begin
    if (!link_rstn)
    begin
      scl_d_ff <= 1'h1;
      sda_d_ff <= 1'h1;
    end
    else
    begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;

  assign addr_match = (shreg_ff[7:1] == {SLAVE_ADDR_HI, low_bit_link});

  // Reads are refused by not acknowledging the address
  always_comb
  begin
    case (state_ff)
      ST_ADDR:
      begin
        ack_byte     = addr_match & (shreg_ff[0] == RW_WRITE);
        follow_state = ST_REG;
      end
      ST_REG:
      begin
        ack_byte     = 1'h1;
        follow_state = ST_DATA;
      end
      ST_DATA:
      begin
        ack_byte     = 1'h1;
        follow_state = ST_DATA;
      end
      default:
      begin
        ack_byte     = 1'h0;
        follow_state = ST_IDLE;
      end
    endcase
  end

  assign byte_end = scl_fall & byte_done_ff;

  // Frame sequencing and bit shifting
  always_ff @(posedge link_clk)
  begin
    if (!link_rstn)
    begin
      state_ff     <= ST_IDLE;
      ack_next_ff  <= ST_IDLE;
      bitcnt_ff    <= 3'h0;
      byte_done_ff <= 1'h0;
      shreg_ff     <= REG_RESET_VAL;
    end
    else if (start_det)
    begin
      state_ff     <= ST_ADDR;
      bitcnt_ff    <= 3'h0;
      byte_done_ff <= 1'h0;
    end
    else if (stop_det)
    begin
      state_ff     <= ST_IDLE;
      byte_done_ff <= 1'h0;
    end
    else
    begin
      case (state_ff)
        ST_ADDR, ST_REG, ST_DATA:
        begin
          if (scl_rise)
          begin
            shreg_ff  <= {shreg_ff[6:0], sda_s};
            bitcnt_ff <= bitcnt_ff + BIT_STEP;
            if (bitcnt_ff == BYTE_LAST_BIT)
            begin
              byte_done_ff <= 1'h1;
            end
          end
          else if (byte_end)
          begin
            byte_done_ff <= 1'h0;
            ack_next_ff  <= follow_state;
            state_ff     <= ack_byte ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            state_ff  <= ack_next_ff;
            bitcnt_ff <= 3'h0;
          end
        end
        default:
        begin
          state_ff <= state_ff;
        end
      endcase
    end
  end

  // Acknowledge drive: held low for the whole ninth clock
  always_ff @(posedge link_clk)
  begin
    if (!link_rstn)
    begin
      sda_oe_ff  <= 1'h0;
      sda_out_ff <= SDA_DRIVE_LOW;
    end
    else
    begin
      sda_out_ff <= SDA_DRIVE_LOW;
      if (start_det || stop_det)
      begin
        sda_oe_ff <= 1'h0;
      end
      else if (byte_end && ack_byte)
      begin
        sda_oe_ff <= 1'h1;
      end
      else if ((state_ff == ST_ACK) && scl_fall)
      begin
        sda_oe_ff <= 1'h0;
      end
    end
  end

  // Register pointer and write hand-off; words stay stable until the next byte
  always_ff @(posedge link_clk)
  begin
    if (!link_rstn)
    begin
      ptr_ff     <= REG_RESET_VAL;
      wr_tog_ff  <= 1'h0;
      wr_addr_ff <= REG_RESET_VAL;
      wr_data_ff <= REG_RESET_VAL;
    end
    else if (byte_end)
    begin
      if (state_ff == ST_REG)
      begin
        ptr_ff <= shreg_ff;
      end
      else if (state_ff == ST_DATA)
      begin
        wr_addr_ff <= ptr_ff;
        wr_data_ff <= shreg_ff;
        wr_tog_ff  <= ~wr_tog_ff;
        ptr_ff     <= ptr_ff + PTR_STEP;
      end
    end
  end

  assign sda_oe  = sda_oe_ff;
  assign sda_out = sda_out_ff;

  // System side: write event crossing
  tisa_sync #(
    .WIDTH (1)
  ) u_tog_sync (
    .clk (clk),
    .d   (wr_tog_ff),
    .q   (tog_s)
  );

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tog_d_ff <= 1'h0;
    end
    else
    begin
      tog_d_ff <= tog_s;
    end
  end

  assign wr_fire = tog_s ^ tog_d_ff;

  // Unmapped register addresses are written into nothing
  assign latch_set_we = wr_fire && (wr_addr_ff == LATCH_SET_ADDR);
  assign latch_clr_we = wr_fire && (wr_addr_ff == LATCH_CLR_ADDR);
  assign fall_set_we  = wr_fire && (wr_addr_ff == FALL_SET_ADDR);
  assign fall_clr_we  = wr_fire && (wr_addr_ff == FALL_CLR_ADDR);
  assign rise_set_we  = wr_fire && (wr_addr_ff == RISE_SET_ADDR);
  assign rise_clr_we  = wr_fire && (wr_addr_ff == RISE_CLR_ADDR);

  // Strap capture at reset release
  tisa_sync #(
    .WIDTH (1)
  ) u_strap_sync (
    .clk (clk),
    .d   (addr_strap_pin),
    .q   (strap_s)
  );

  // Low address bit is not reset, only loaded on release; power-up value is zero
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      in_reset_ff <= 1'h1;
    end
    else if (in_reset_ff)
    begin
      in_reset_ff     <= 1'h0;
      addr_low_bit_ff <= strap_s;
    end
  end

  assign addr_low_bit = addr_low_bit_ff;

  // Source edge detection
  assign src_raw = {plus_line_irq_src, disc_conn_src, id_open_src, minus_line_high_src,
                    id_grounded_src, plus_line_high_src, session_ok_src, bus_volt_ok_src};

  tisa_sync #(
    .WIDTH (8)
  ) u_src_sync (
    .clk (clk),
    .d   (src_raw),
    .q   (src_s)
  );

  // First cycle after reset only primes the history, so static levels raise nothing
  always_ff @(posedge clk)
  begin
    src_prev_ff <= src_s;
    if (!resetn)
    begin
      primed_ff <= 1'h0;
    end
    else
    begin
      primed_ff <= 1'h1;
    end
  end

  assign src_rise     = {8{primed_ff}} & src_s & ~src_prev_ff;
  assign src_fall     = {8{primed_ff}} & ~src_s & src_prev_ff;
  assign latch_hw_set = (src_rise & rise_q) | (src_fall & fall_q);

  tisa_srreg #(
    .RSV_MASK (NO_RSV_MASK)
  ) u_latch_reg (
    .clk    (clk),
    .resetn (resetn),
    .set_we (latch_set_we),
    .clr_we (latch_clr_we),
    .wdata  (wr_data_ff),
    .hw_set (latch_hw_set),
    .q      (latch_q)
  );

  tisa_srreg #(
    .RSV_MASK (FALL_RSV_MASK)
  ) u_fall_reg (
    .clk    (clk),
    .resetn (resetn),
    .set_we (fall_set_we),
    .clr_we (fall_clr_we),
    .wdata  (wr_data_ff),
    .hw_set (REG_RESET_VAL),
    .q      (fall_q)
  );

  tisa_srreg #(
    .RSV_MASK (NO_RSV_MASK)
  ) u_rise_reg (
    .clk    (clk),
    .resetn (resetn),
    .set_we (rise_set_we),
    .clr_we (rise_clr_we),
    .wdata  (wr_data_ff),
    .hw_set (REG_RESET_VAL),
    .q      (rise_q)
  );

  // Interrupt pin and status view
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      int_n_ff     <= 1'h1;
      src_level_ff <= REG_RESET_VAL;
    end
    else
    begin
      int_n_ff     <= ~(|latch_q);
      src_level_ff <= src_s;
    end
  end

  assign int_n         = int_n_ff;
  assign src_level     = src_level_ff;
  assign latch_state   = latch_q;
  assign rise_en_state = rise_q;
  assign fall_en_state = fall_q;

endmodule

// >>> testbench/tisa_top_sva.sv
// Concurrent checks on the interrupt latch and serial front-end ports
module tisa_top_chk (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       link_clk,
  input wire logic       scl_in,
  input wire logic       sda_oe,
  input wire logic       addr_strap_pin,
  input wire logic       int_n,
  input wire logic       addr_low_bit,
  input wire logic [7:0] src_level,
  input wire logic [7:0] latch_state,
  input wire logic [7:0] rise_en_state,
  input wire logic [7:0] fall_en_state
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] src_q_ff;
  logic [7:0] rise_hit;
  logic [7:0] fall_hit;

  // Previous level, so edges are judged on the synchronised copy only
  always_ff @(posedge clk)
  begin
    src_q_ff <= src_level;
  end
  assign rise_hit = src_level & ~src_q_ff & rise_en_state;
  assign fall_hit = ~src_level & src_q_ff & fall_en_state;

  a_irq_asserted: assert property (@(posedge clk) disable iff (!resetn)
    (latch_state != 8'h00) |=> !int_n) else $error("int_n not low with latch set");
  a_irq_idle: assert property (@(posedge clk) disable iff (!resetn)
    (latch_state == 8'h00) |=> int_n) else $error("int_n low with latch empty");
  a_irq_release: assert property (@(posedge clk) disable iff (!resetn)
    $rose(int_n) |-> ($past(latch_state) == 8'h00)) else $error("int_n released early");
  a_rise_latch: assert property (@(posedge clk) disable iff (!resetn)
    (rise_hit != 8'h00) |-> ##2 ((latch_state & $past(rise_hit, 2)) == $past(rise_hit, 2)))
    else $error("rising edge not latched");
  a_fall_latch: assert property (@(posedge clk) disable iff (!resetn)
    (fall_hit != 8'h00) |-> ##2 ((latch_state & $past(fall_hit, 2)) == $past(fall_hit, 2)))
    else $error("falling edge not latched");
  a_fall_reserved: assert property (@(posedge clk) disable iff (!resetn)
    fall_en_state[6] == 1'b0) else $error("reserved fall enable bit set");
  a_reset_clear: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |-> (latch_state == 8'h00 && rise_en_state == 8'h00 &&
    fall_en_state == 8'h00 && int_n)) else $error("register not cleared by reset");
  a_strap_capture: assert property (@(posedge clk) disable iff (!resetn)
    $rose(resetn) |=> (addr_low_bit == $past(addr_strap_pin)))
    else $error("address bit not taken from strap");
  a_strap_hold: assert property (@(posedge clk) disable iff (!resetn)
    ($past(resetn) && $past(resetn, 2)) |-> $stable(addr_low_bit))
    else $error("address bit changed after capture");
  a_ack_stands: assert property (@(posedge link_clk) disable iff (!resetn)
    $rose(sda_oe) |-> sda_oe [*4]) else $error("acknowledge too short");
  a_ack_scl_low: assert property (@(posedge link_clk) disable iff (!resetn)
    $rose(sda_oe) |-> !scl_in) else $error("acknowledge starts with clock high");
endmodule

bind tisa_top tisa_top_chk u_chk (
  .clk, .resetn, .link_clk, .scl_in, .sda_oe, .addr_strap_pin, .int_n,
  .addr_low_bit, .src_level, .latch_state, .rise_en_state, .fall_en_state
);

// >>> testbench/tisa_host_model.sv
// Serial bus master model pulling the open-drain clock and data lines
module tisa_host_model (
  input  wire logic clk,
  input  wire logic sda_in,
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // 200 ns step; each clock phase lasts two steps, above four link periods
  localparam int HALF = 50;

  // Clock stands high between frames
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic start_c();
    sda_low <= 1'b1;
    gap(2 * HALF);
    scl_low <= 1'b1;
    gap(HALF);
  endtask

  // Most significant bit first, ninth pulse samples the acknowledge
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_low <= !b[i];
      gap(HALF);
      scl_low <= 1'b0;
      gap(2 * HALF);
      scl_low <= 1'b1;
      gap(HALF);
    end
    sda_low <= 1'b0;
    gap(HALF);
    scl_low <= 1'b0;
    gap(HALF);
    ack = !sda_in;
    gap(HALF);
    scl_low <= 1'b1;
    gap(HALF);
  endtask

  task automatic stop_c();
    sda_low <= 1'b1;
    gap(HALF);
    scl_low <= 1'b0;
    gap(HALF);
    sda_low <= 1'b0;
    gap(2 * HALF);
  endtask
endmodule

// >>> testbench/tb_transceiver_irq_and_serial_access.sv
// Self-checking bench for the interrupt latch and serial write front-end
module tb_transceiver_irq_and_serial_access
  import tisa_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk;
  logic       resetn;
  logic       link_clk;
  logic       strap;
  logic [7:0] src;
  logic       scl_low;
  logic       sda_low;
  logic       scl_w;
  logic       sda_w;
  logic       sda_out;
  logic       sda_oe;
  logic       int_n;
  logic       addr_low_bit;
  logic [7:0] src_level;
  logic [7:0] latch_state;
  logic [7:0] rise_en_state;
  logic [7:0] fall_en_state;
  int         bad_count;
  int         check_count;

  // Pull-ups on both lines
  assign scl_w = !scl_low;
  assign sda_w = !(sda_low || (sda_oe && (sda_out == 1'b0)));

  always #2 clk = ~clk;

  initial
  begin
    link_clk = 1'b0;
    #1.5;
    forever #32 link_clk = ~link_clk;
  end

  tisa_top u_dut (
    .clk                 (clk),
    .resetn              (resetn),
    .link_clk            (link_clk),
    .scl_in              (scl_w),
    .sda_in              (sda_w),
    .sda_out             (sda_out),
    .sda_oe              (sda_oe),
    .addr_strap_pin      (strap),
    .plus_line_irq_src   (src[7]),
    .disc_conn_src       (src[6]),
    .id_open_src         (src[5]),
    .minus_line_high_src (src[4]),
    .id_grounded_src     (src[3]),
    .plus_line_high_src  (src[2]),
    .session_ok_src      (src[1]),
    .bus_volt_ok_src     (src[0]),
    .int_n               (int_n),
    .addr_low_bit        (addr_low_bit),
    .src_level           (src_level),
    .latch_state         (latch_state),
    .rise_en_state       (rise_en_state),
    .fall_en_state       (fall_en_state)
  );

  tisa_host_model u_host (
    .clk     (clk),
    .sda_in  (sda_w),
    .scl_low (scl_low),
    .sda_low (sda_low)
  );

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Only the strapped write address 0101 1010 is acknowledged
  task automatic frame(input logic [7:0] sel, input logic [7:0] rg,
                       input logic [23:0] d, input int n);
    logic ack;
    u_host.start_c();
    u_host.send_byte(sel, ack);
    chk("address ack", {7'h00, sel == 8'h5A}, {7'h00, ack});
    if (ack === 1'b1)
    begin
      u_host.send_byte(rg, ack);
      chk("register ack", 8'h01, {7'h00, ack});
      for (int i = 0; i < n; i++)
      begin
        u_host.send_byte(d[23 - 8 * i -: 8], ack);
        chk("data ack", 8'h01, {7'h00, ack});
      end
    end
    u_host.stop_c();
    gap(10);
  endtask

  task automatic set_src(input logic [7:0] v);
    @(posedge clk);
    src <= v;
    gap(10);
  endtask

  task automatic wait_int(input logic lvl);
    int k;
    k = 0;
    while (int_n !== lvl && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    chk("int_n", {7'h00, lvl}, {7'h00, int_n});
    if (int_n !== lvl)
      results();
  endtask

  // Watchdog for a stuck transfer
  initial
  begin
    gap(90000);
    bad_count++;
    results();
  end

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    strap = 1'b1;
    src = 8'h00;
    bad_count = 0;
    check_count = 0;
    // Held in link periods so the link side sees the reset too
    repeat (6) @(posedge link_clk);
    @(posedge clk);
    resetn <= 1'b1;
    gap(3);
    chk("latch", 8'h00, latch_state);
    chk("rise", 8'h00, rise_en_state);
    chk("fall", 8'h00, fall_en_state);
    chk("int_n", 8'h01, {7'h00, int_n});
    chk("addr bit", 8'h01, {7'h00, addr_low_bit});
    $display("test reset done");
    // Link side leaves reset some link periods after the system side
    gap(80);
    frame(8'h58, 8'h00, 24'h000000, 0);
    frame(8'h5B, 8'h00, 24'h000000, 0);
    $display("test address done");
    frame(8'h5A, FALL_SET_ADDR, 24'hFF00FF, 3);
    chk("fall", 8'hBF, fall_en_state);
    chk("rise", 8'hFF, rise_en_state);
    $display("test burst done");
    set_src(8'h01);
    wait_int(1'b0);
    chk("latch", 8'h01, latch_state);
    chk("level", 8'h01, src_level);
    frame(8'h5A, LATCH_CLR_ADDR, 24'h010000, 1);
    wait_int(1'b1);
    set_src(8'h00);
    chk("latch", 8'h01, latch_state);
    set_src(8'h40);
    set_src(8'h00);
    chk("latch", 8'h41, latch_state);
    frame(8'h5A, LATCH_CLR_ADDR, 24'h010000, 1);
    chk("latch", 8'h40, latch_state);
    chk("int_n", 8'h00, {7'h00, int_n});
    $display("test edges done");
    // Second byte lands on an unmapped address and must be dropped
    frame(8'h5A, RISE_CLR_ADDR, 24'hFFFF00, 2);
    chk("rise", 8'h00, rise_en_state);
    set_src(8'hFF);
    chk("latch", 8'h40, latch_state);
    set_src(8'h00);
    chk("latch", 8'hFF, latch_state);
    frame(8'h5A, LATCH_CLR_ADDR, 24'hFF0000, 1);
    wait_int(1'b1);
    frame(8'h5A, LATCH_SET_ADDR, 24'h240000, 1);
    chk("latch", 8'h24, latch_state);
    wait_int(1'b0);
    $display("test software set done");
    results();
  end
endmodule
